// file: include/adcsr_pkg.sv
/*
 * Shared constants and types for the asynchronous DRAM host controller:
 * pin widths, cycle kinds, controller states and every timing figure.
 * Assumes a single 125 MHz clock; timings are those of the fastest grade.
 */
package adcsr_pkg;

	// ****************************************************************
	// widths
	// ****************************************************************
	localparam int ADDR_W = 18;
	localparam int PIN_ADDR_W = 9;
	localparam int DATA_W = 16;
	localparam int CNT_W = 16;
	localparam int ROWS_W = 10;
	localparam int INIT_W = 4;
	localparam int CLK_PS = 8000;

	// ****************************************************************
	// times as printed, in their own units
	// ****************************************************************
	localparam int T_RP_NS = 40;
	localparam int T_RAS_NS = 60;
	localparam int T_RC_NS = 110;
	localparam int T_RCD_NS = 20;
	localparam int T_AA_NS = 30;
	localparam int T_CAC_NS = 15;
	localparam int T_RAC_NS = 60;
	localparam int T_OFF_NS = 15;
	localparam int T_DH_NS = 15;
	localparam int T_CSR_NS = 10;
	localparam int T_RPS_NS = 110;
	localparam int T_INIT_US = 100;
	localparam int T_SR_MIN_US = 100;
	localparam int T_SR_TRANS_US = 10;
	localparam int T_REF_INT_NS = 15600;
	localparam int INIT_REF_COUNT = 8;
	localparam int ROWS_TOTAL = 512;
	localparam int REF_SLACK_CYC = 64;

	// least times round up, longest times round down, never below one cycle
	function automatic int cyc_min(int ps);
		int c;
		c = (ps + CLK_PS - 1) / CLK_PS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int cyc_max(int ps);
		int c;
		c = ps / CLK_PS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int imax(int a, int b);
		return (a > b) ? a : b;
	endfunction

	// ****************************************************************
	// cycle counts
	// ****************************************************************
	localparam int RCD_CYC = cyc_min(T_RCD_NS * 1000);
	localparam int RAS_CYC = cyc_min(T_RAS_NS * 1000);
	localparam int ACC_CYC = imax(imax(cyc_min(T_AA_NS * 1000), cyc_min(T_CAC_NS * 1000)),
		cyc_min(T_RAC_NS * 1000) - RCD_CYC);
	localparam int PRE_CYC = imax(cyc_min(T_RP_NS * 1000), cyc_min(T_RC_NS * 1000) - RAS_CYC);
	localparam int OFF_CYC = cyc_min(T_OFF_NS * 1000);
	localparam int WP_CYC = cyc_min(T_DH_NS * 1000);
	localparam int CSR_CYC = cyc_min(T_CSR_NS * 1000);
	localparam int RPS_CYC = cyc_min(T_RPS_NS * 1000);
	localparam int INIT_WAIT_CYC_DEF = cyc_min(T_INIT_US * 1000000);
	localparam int SR_MIN_CYC_DEF = cyc_min(T_SR_MIN_US * 1000000);
	localparam int SR_TRANS_CYC = cyc_max(T_SR_TRANS_US * 1000000);
	localparam int REF_INT_CYC = cyc_max(T_REF_INT_NS * 1000);

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {KIND_READ, KIND_WRITE, KIND_RMW} adcsr_kind_t;

	typedef enum logic [1:0] {SR_NONE, SR_PRELUDE, SR_ENTER} adcsr_sr_t;

	typedef enum logic [3:0] {
		ST_BOOT, ST_INIT_WAIT, ST_IDLE, ST_RAS, ST_CAS, ST_ACC, ST_TURN, ST_WRT,
		ST_PRE, ST_CBR_RAS, ST_CBR_HOLD, ST_SR_HOLD
	} adcsr_state_t;

endpackage

// file: verification/adcsr_ctrl_tb_top.sv
/* self-checking bench for the controller against the dram model.
 * assumes the 8 ns clock and a short power-up pause parameter. */
`timescale 1ns/1ps
module adcsr_ctrl_tb_top;
	import adcsr_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	logic sr_req = 1'b0;
	adcsr_kind_t req_kind = KIND_READ;
	logic [ADDR_W-1:0] req_addr = 18'h0;
	logic [DATA_W-1:0] req_wdata = 16'h0;
	logic [1:0] req_byte_en = 2'h3;
	logic req_ready, rd_valid, sr_active, init_done, ras_n, upper_byte_col_strobe_n_n, lower_byte_col_strobe_n_n, we_n, oe_n, dq_oe;
	logic [DATA_W-1:0] rd_data, dq_out, dev_out, q;
	logic [PIN_ADDR_W-1:0] pin_addr;
	logic [15:0] cbr_cnt, gap_max, viol_cnt;
	int n_mismatch = 0;
	int cmp_count = 0;
	wire [DATA_W-1:0] dq_in = dq_oe ? dq_out : dev_out;
	always #4 clk = ~clk;
	adcsr_ctrl #(.INIT_WAIT_CYC(20), .SR_MIN_CYC(1300)) dut_u (.clk(clk), .rst_n(rst_n),
		.req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_byte_en(req_byte_en),
		.rd_valid(rd_valid), .rd_data(rd_data), .sr_req(sr_req), .sr_active(sr_active),
		.init_done(init_done), .dram_ras_n(ras_n), .upper_byte_col_strobe_n(upper_byte_col_strobe_n_n),
		.lower_byte_col_strobe_n(lower_byte_col_strobe_n_n), .dram_we_n(we_n), .dram_oe_n(oe_n),
		.dram_addr(pin_addr), .dram_dq_out(dq_out), .dram_dq_oe(dq_oe), .dram_dq_in(dq_in));
	adcsr_dram_model mem_u (.clk(clk), .ras_n(ras_n), .upper_byte_col_strobe_n_n(upper_byte_col_strobe_n_n), .lower_byte_col_strobe_n_n(lower_byte_col_strobe_n_n),
		.we_n(we_n), .oe_n(oe_n), .addr(pin_addr), .din(dq_out), .din_oe(dq_oe),
		.dout(dev_out), .cbr_cnt(cbr_cnt), .gap_max(gap_max), .viol_cnt(viol_cnt));
	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD data t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_flag(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD flag t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// holds the request until ready is seen high at a falling edge, then drops it at the next rising edge
	task automatic req(input adcsr_kind_t k, input logic [17:0] a, input logic [15:0] d,
		input logic [1:0] be);
		int i;
		@(posedge clk);
		req_valid <= 1'b1;
		req_kind <= k;
		req_addr <= a;
		req_wdata <= d;
		req_byte_en <= be;
		i = 0;
		do begin
			@(negedge clk);
			i++;
		end while (req_ready !== 1'b1 && i < 3000);
		chk_flag(req_ready, 1'b1);
		@(posedge clk);
		req_valid <= 1'b0;
		q = 16'hx;
		i = 0;
		if (k != KIND_WRITE) begin
			do begin
				@(negedge clk);
				i++;
			end while (rd_valid !== 1'b1 && i < 50);
			chk_data(16'(i), 16'(2 + RCD_CYC + ACC_CYC));
			q = rd_data;
		end
	endtask
	task automatic summarize();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_init();
		int i;
		i = 0;
		while (init_done !== 1'b1 && i < 2000) begin
			@(negedge clk);
			i++;
		end
		chk_flag(init_done, 1'b1);
		chk_flag(cbr_cnt >= 16'h8, 1'b1);
	endtask
	task automatic t_lanes();
		req(KIND_WRITE, 18'h0a05, 16'h1234, 2'h3);
		req(KIND_WRITE, 18'h3fe01, 16'hbeef, 2'h3);
		req(KIND_WRITE, 18'h0a05, 16'hab00, 2'h2);
		req(KIND_READ, 18'h0a05, 16'h0, 2'h3);
		chk_data(q, 16'hab34);
		req(KIND_READ, 18'h3fe01, 16'h0, 2'h3);
		chk_data(q, 16'hbeef);
	endtask
	task automatic t_rmw();
		req(KIND_RMW, 18'h0a05, 16'h5a5a, 2'h3);
		chk_data(q, 16'hab34);
		req(KIND_READ, 18'h0a05, 16'h0, 2'h3);
		chk_data(q, 16'h5a5a);
	endtask
	task automatic t_sr_refused();
		logic seen;
		seen = 1'b0;
		@(posedge clk);
		sr_req <= 1'b1;
		repeat (200) begin
			@(negedge clk);
			seen = seen | (sr_active !== 1'b0);
		end
		@(posedge clk);
		sr_req <= 1'b0;
		chk_flag(seen, 1'b0);
	endtask
	task automatic t_refresh();
		logic [15:0] c0;
		c0 = cbr_cnt;
		repeat (6000) @(posedge clk);
		chk_flag(cbr_cnt >= c0 + 16'h3, 1'b1);
		chk_flag(gap_max <= REF_INT_CYC, 1'b1);
		chk_data(viol_cnt, 16'h0);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_init();
		t_lanes();
		t_rmw();
		t_sr_refused();
		t_refresh();
		summarize();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		summarize();
	end
endmodule // adcsr_ctrl_tb_top

// file: verification/adcsr_dram_model.sv
/* dram model for the host controller bench.
 * assumes the pins are registered on clk and samples them at rising edges. */
`timescale 1ns/1ps
module adcsr_dram_model
	import adcsr_pkg::*;
(
	// clock
	input wire logic clk,
	// strobes and address
	input wire logic ras_n,
	input wire logic upper_byte_col_strobe_n_n,
	input wire logic lower_byte_col_strobe_n_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [PIN_ADDR_W-1:0] addr,
	// data pins
	input wire logic [DATA_W-1:0] din,
	input wire logic din_oe,
	output logic [DATA_W-1:0] dout,
	// bookkeeping
	output logic [15:0] cbr_cnt,
	output logic [15:0] gap_max,
	output logic [15:0] viol_cnt
);
	// ****************************************************************
	// behaviour
	// ****************************************************************
	// short latency: samples lag the pins by one edge already
	localparam int ACC_LAT = 3;
	logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
	logic [PIN_ADDR_W-1:0] row_q;
	logic [PIN_ADDR_W-1:0] col_q;
	logic ras_q = 1'b1;
	logic u_q = 1'b1;
	logic l_q = 1'b1;
	logic we_q = 1'b1;
	logic [15:0] gap = 16'h0;
	int acc = 0;
	wire cas_any = !(upper_byte_col_strobe_n_n && lower_byte_col_strobe_n_n);
	wire cas_was = !(u_q && l_q);
	wire rd_on = !ras_n && cas_any && we_n && !oe_n;
	wire wr = !ras_n && cas_any && !we_n && (!cas_was || we_q);
	wire [ADDR_W-1:0] key = {row_q, cas_was ? col_q : addr};
	initial begin
		cbr_cnt = 16'h0;
		gap_max = 16'h0;
		viol_cnt = 16'h0;
		dout = 16'h0;
	end
	always @(posedge clk) begin
		ras_q <= ras_n;
		u_q <= upper_byte_col_strobe_n_n;
		l_q <= lower_byte_col_strobe_n_n;
		we_q <= we_n;
		gap <= gap + 16'h1;
		if (ras_q && !ras_n && cas_any) begin
			cbr_cnt <= cbr_cnt + 16'h1;
			// the power-up burst is packed, so spacing counts from then on
			if (cbr_cnt >= 16'h8 && gap > gap_max)
				gap_max <= gap;
			gap <= 16'h0;
		end else if (ras_q && !ras_n)
			row_q <= addr;
		if (cas_any && !cas_was)
			col_q <= addr;
		if ((u_q && !upper_byte_col_strobe_n_n && !l_q) || (l_q && !lower_byte_col_strobe_n_n && !u_q) || (din_oe && !oe_n))
			viol_cnt <= viol_cnt + 16'h1;
		if (wr && !upper_byte_col_strobe_n_n)
			mem[key][15:8] = din[15:8];
		if (wr && !lower_byte_col_strobe_n_n)
			mem[key][7:0] = din[7:0];
		acc <= (rd_on === 1'b1) ? acc + 1 : 0;
		// released pins show the inverse, never a stale copy
		dout <= (rd_on === 1'b1 && acc >= ACC_LAT) ? mem[{row_q, col_q}] : ~dout;
	end
endmodule // adcsr_dram_model

// file: verilog/adcsr_ctrl.sv
/*
 * Host-side sequencer for a 256K x 16 asynchronous page DRAM: power-up
 * initialisation, read, early write, read-modify-write, distributed
 * column-before-row refresh and self refresh entry and exit.
 * Assumes the data pins are resolved outside from dram_dq_oe and that
 * dram_dq_in is synchronous to clk.
 */
`timescale 1ns/1ps
module adcsr_ctrl #(
	parameter int INIT_WAIT_CYC = adcsr_pkg::INIT_WAIT_CYC_DEF,
	parameter int SR_MIN_CYC = adcsr_pkg::SR_MIN_CYC_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// user request
	input wire logic req_valid,
	output logic req_ready,
	input wire adcsr_pkg::adcsr_kind_t req_kind,
	input wire logic [adcsr_pkg::ADDR_W-1:0] req_addr,
	input wire logic [adcsr_pkg::DATA_W-1:0] req_wdata,
	input wire logic [1:0] req_byte_en,
	// read answer
	output logic rd_valid,
	output logic [adcsr_pkg::DATA_W-1:0] rd_data,
	// power state
	input wire logic sr_req,
	output logic sr_active,
	output logic init_done,
	// memory pins
	output logic dram_ras_n,
	output logic upper_byte_col_strobe_n,
	output logic lower_byte_col_strobe_n,
	output logic dram_we_n,
	output logic dram_oe_n,
	output logic [adcsr_pkg::PIN_ADDR_W-1:0] dram_addr,
	output logic [adcsr_pkg::DATA_W-1:0] dram_dq_out,
	output logic dram_dq_oe,
	input wire logic [adcsr_pkg::DATA_W-1:0] dram_dq_in
);
	import adcsr_pkg::*;

	// ****************************************************************
	// state
	// ****************************************************************
	adcsr_state_t state_reg, state_next;
	adcsr_kind_t kind_reg, kind_next;
	adcsr_sr_t sr_phase_reg, sr_phase_next;
	logic ras_reg, ras_next, upper_byte_col_strobe_n_reg, upper_byte_col_strobe_n_next, lower_byte_col_strobe_n_reg, lower_byte_col_strobe_n_next;
	logic we_reg, we_next, oe_reg, oe_next, dq_oe_reg, dq_oe_next;
	logic [PIN_ADDR_W-1:0] addr_reg, addr_next, col_reg, col_next;
	logic [DATA_W-1:0] dq_out_reg, dq_out_next, wdata_reg, wdata_next;
	logic [DATA_W-1:0] rd_data_reg, rd_data_next;
	logic [1:0] be_reg, be_next;
	logic rd_valid_reg, rd_valid_next, ready_reg, ready_next;
	logic sr_active_reg, sr_active_next, init_done_reg, init_done_next;
	logic [INIT_W-1:0] init_cnt_reg, init_cnt_next;
	logic dly_load, dly_done, cbr_done, sr_exit, ref_due, rows_ok;
	logic [CNT_W-1:0] dly_val;

	// ****************************************************************
	// decode
	// ****************************************************************
	wire accept = req_valid && ready_reg;
	wire sr_go = init_done_reg && sr_req && rows_ok && (sr_phase_reg == SR_NONE);
	wire init_more = !init_done_reg && (init_cnt_reg != INIT_W'(INIT_REF_COUNT));
	wire want_cbr = init_more || (init_done_reg && ref_due) || sr_go;
	// an empty byte mask still runs both lanes so the cycle stays whole
	wire [1:0] be_eff = (req_byte_en == 2'b00) ? 2'b11 : req_byte_en;
	wire [DATA_W-1:0] rd_capture = dram_dq_in;

	adcsr_delay u_delay (
		.clk(clk),
		.rst_n(rst_n),
		.load(dly_load),
		.load_val(dly_val),
		.done(dly_done)
	);

	adcsr_refresh u_refresh (
		.clk(clk),
		.rst_n(rst_n),
		.cbr_done(cbr_done),
		.sr_exit(sr_exit),
		.ref_due(ref_due),
		.rows_ok(rows_ok)
	);

	// ****************************************************************
	// sequencer
	// ****************************************************************
	always_comb begin
		state_next = state_reg;
		kind_next = kind_reg;
		sr_phase_next = sr_phase_reg;
		ras_next = ras_reg;
		upper_byte_col_strobe_n_next = upper_byte_col_strobe_n_reg;
		lower_byte_col_strobe_n_next = lower_byte_col_strobe_n_reg;
		we_next = we_reg;
		oe_next = oe_reg;
		dq_oe_next = dq_oe_reg;
		addr_next = addr_reg;
		col_next = col_reg;
		dq_out_next = dq_out_reg;
		wdata_next = wdata_reg;
		be_next = be_reg;
		rd_data_next = rd_data_reg;
		rd_valid_next = 1'b0;
		sr_active_next = sr_active_reg;
		init_done_next = init_done_reg;
		init_cnt_next = init_cnt_reg;
		dly_load = 1'b0;
		dly_val = '0;
		cbr_done = 1'b0;
		sr_exit = 1'b0;
		case (state_reg)
			ST_BOOT: begin
				dly_load = 1'b1;
				dly_val = CNT_W'(INIT_WAIT_CYC - 1);
				state_next = ST_INIT_WAIT;
			end
			ST_INIT_WAIT: begin
				if (dly_done) begin
					state_next = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (accept) begin
					kind_next = req_kind;
					wdata_next = req_wdata;
					be_next = be_eff;
					addr_next = req_addr[ADDR_W-1:PIN_ADDR_W];
					col_next = req_addr[PIN_ADDR_W-1:0];
					dly_load = 1'b1;
					state_next = ST_RAS;
				end else if (want_cbr) begin
					// column strobes lead the row strobe
					upper_byte_col_strobe_n_next = 1'b0;
					lower_byte_col_strobe_n_next = 1'b0;
					dly_load = 1'b1;
					dly_val = CNT_W'(CSR_CYC - 1);
					sr_phase_next = sr_go ? SR_PRELUDE : SR_NONE;
					state_next = ST_CBR_RAS;
				end else if (!init_done_reg) begin
					init_done_next = 1'b1;
				end
			end
			ST_RAS: begin
				if (dly_done) begin
					ras_next = 1'b0;
					dly_load = 1'b1;
					dly_val = CNT_W'(RCD_CYC - 1);
					if (kind_reg == KIND_WRITE) begin
						// write strobe and data lead the column strobe
						we_next = 1'b0;
						dq_oe_next = 1'b1;
						dq_out_next = wdata_reg;
					end
					state_next = ST_CAS;
				end
			end
			ST_CAS: begin
				if (dly_done) begin
					addr_next = col_reg;
					// enabled lanes fall on one edge, one cycle kind for both
					upper_byte_col_strobe_n_next = !be_reg[1];
					lower_byte_col_strobe_n_next = !be_reg[0];
					oe_next = (kind_reg == KIND_WRITE);
					dly_load = 1'b1;
					dly_val = CNT_W'(ACC_CYC - 1);
					state_next = ST_ACC;
				end
			end
			ST_ACC: begin
				if (dly_done) begin
					dly_load = 1'b1;
					if (kind_reg != KIND_WRITE) begin
						rd_data_next = rd_capture;
						rd_valid_next = 1'b1;
						oe_next = 1'b1;
					end
					if (kind_reg == KIND_RMW) begin
						// drivers must be off before our data goes on the pins
						dly_val = CNT_W'(OFF_CYC - 1);
						state_next = ST_TURN;
					end else begin
						ras_next = 1'b1;
						upper_byte_col_strobe_n_next = 1'b1;
						lower_byte_col_strobe_n_next = 1'b1;
						we_next = 1'b1;
						dq_oe_next = 1'b0;
						dly_val = CNT_W'(PRE_CYC - 1);
						state_next = ST_PRE;
					end
				end
			end
			ST_TURN: begin
				if (dly_done) begin
					we_next = 1'b0;
					dq_oe_next = 1'b1;
					dq_out_next = wdata_reg;
					dly_load = 1'b1;
					dly_val = CNT_W'(WP_CYC - 1);
					state_next = ST_WRT;
				end
			end
			ST_WRT: begin
				if (dly_done) begin
					ras_next = 1'b1;
					upper_byte_col_strobe_n_next = 1'b1;
					lower_byte_col_strobe_n_next = 1'b1;
					we_next = 1'b1;
					dq_oe_next = 1'b0;
					dly_load = 1'b1;
					dly_val = CNT_W'(PRE_CYC - 1);
					state_next = ST_PRE;
				end
			end
			ST_CBR_RAS: begin
				if (dly_done) begin
					ras_next = 1'b0;
					dly_load = 1'b1;
					if (sr_phase_reg == SR_ENTER) begin
						sr_active_next = 1'b1;
						dly_val = CNT_W'(SR_MIN_CYC - 1);
						state_next = ST_SR_HOLD;
					end else begin
						dly_val = CNT_W'(RAS_CYC - 1);
						state_next = ST_CBR_HOLD;
					end
				end
			end
			ST_CBR_HOLD: begin
				if (dly_done) begin
					ras_next = 1'b1;
					upper_byte_col_strobe_n_next = 1'b1;
					lower_byte_col_strobe_n_next = 1'b1;
					cbr_done = 1'b1;
					if (init_more) begin
						init_cnt_next = init_cnt_reg + 1'b1;
					end
					dly_load = 1'b1;
					dly_val = CNT_W'(PRE_CYC - 1);
					state_next = ST_PRE;
				end
			end
			ST_SR_HOLD: begin
				// held until the minimum has run, never released in the transition window
				if (dly_done && !sr_req) begin
					ras_next = 1'b1;
					upper_byte_col_strobe_n_next = 1'b1;
					lower_byte_col_strobe_n_next = 1'b1;
					sr_active_next = 1'b0;
					sr_exit = 1'b1;
					sr_phase_next = SR_NONE;
					dly_load = 1'b1;
					dly_val = CNT_W'(RPS_CYC - 1);
					state_next = ST_PRE;
				end
			end
			ST_PRE: begin
				if (dly_done && sr_phase_reg == SR_PRELUDE) begin
					upper_byte_col_strobe_n_next = 1'b0;
					lower_byte_col_strobe_n_next = 1'b0;
					sr_phase_next = SR_ENTER;
					dly_load = 1'b1;
					dly_val = CNT_W'(CSR_CYC - 1);
					state_next = ST_CBR_RAS;
				end else if (dly_done) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_BOOT;
			end
		endcase
	end

	assign ready_next = (state_next == ST_IDLE) && init_done_next && !ref_due && !sr_go
		&& !accept;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_BOOT;
			kind_reg <= KIND_READ;
			sr_phase_reg <= SR_NONE;
			{ras_reg, upper_byte_col_strobe_n_reg, lower_byte_col_strobe_n_reg, we_reg, oe_reg} <= 5'h1f;
			{dq_oe_reg, rd_valid_reg, ready_reg, sr_active_reg, init_done_reg} <= 5'h00;
			init_cnt_reg <= '0;
			be_reg <= 2'h3;
		end else begin
			state_reg <= state_next;
			kind_reg <= kind_next;
			sr_phase_reg <= sr_phase_next;
			{ras_reg, upper_byte_col_strobe_n_reg, lower_byte_col_strobe_n_reg, we_reg, oe_reg} <=
				{ras_next, upper_byte_col_strobe_n_next, lower_byte_col_strobe_n_next, we_next, oe_next};
			{dq_oe_reg, rd_valid_reg, ready_reg, sr_active_reg, init_done_reg} <=
				{dq_oe_next, rd_valid_next, ready_next, sr_active_next, init_done_next};
			init_cnt_reg <= init_cnt_next;
			be_reg <= be_next;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{addr_reg, col_reg} <= '0;
			{dq_out_reg, wdata_reg, rd_data_reg} <= '0;
		end else begin
			{addr_reg, col_reg} <= {addr_next, col_next};
			{dq_out_reg, wdata_reg, rd_data_reg} <= {dq_out_next, wdata_next, rd_data_next};
		end
	end

	assign req_ready = ready_reg;
	assign rd_valid = rd_valid_reg;
	assign rd_data = rd_data_reg;
	assign sr_active = sr_active_reg;
	assign init_done = init_done_reg;
	assign dram_ras_n = ras_reg;
	assign upper_byte_col_strobe_n = upper_byte_col_strobe_n_reg;
	assign lower_byte_col_strobe_n = lower_byte_col_strobe_n_reg;
	assign dram_we_n = we_reg;
	assign dram_oe_n = oe_reg;
	assign dram_addr = addr_reg;
	assign dram_dq_out = dq_out_reg;
	assign dram_dq_oe = dq_oe_reg;

	// ****************************************************************
	// checks
	// ****************************************************************
	logic [CNT_W-1:0] ras_low_cnt;
	logic sr_exit_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ras_low_cnt <= '0;
		end else if (ras_reg) begin
			ras_low_cnt <= '0;
		end else if (ras_low_cnt != '1) begin
			ras_low_cnt <= ras_low_cnt + 1'b1;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_oe_off_window;
		(oe_reg && !dq_oe_reg) ##1 (oe_reg && !dq_oe_reg);
	endsequence

	sequence s_cas_lead;
		(!upper_byte_col_strobe_n_reg && !lower_byte_col_strobe_n_reg && ras_reg) ##1 (!upper_byte_col_strobe_n_reg && !lower_byte_col_strobe_n_reg && ras_reg);
	endsequence

	a_init_quiet : assert property (state_reg == ST_INIT_WAIT |-> ras_reg && upper_byte_col_strobe_n_reg)
		else $error("memory strobed during power-up pause");
	a_init_count : assert property ($rose(init_done_reg) |-> init_cnt_reg == 4'h8)
		else $error("initialisation ended without eight refreshes");
	a_early_write : assert property (
		($fell(upper_byte_col_strobe_n_reg) || $fell(lower_byte_col_strobe_n_reg)) && !ras_reg && kind_reg == KIND_WRITE
		|-> !we_reg && dq_oe_reg && oe_reg)
		else $error("early write strobe not ahead of column strobe");
	a_rmw_turn : assert property (
		$rose(oe_reg) && !ras_reg && kind_reg == KIND_RMW |-> s_oe_off_window
		##1 (!we_reg && dq_oe_reg))
		else $error("write data driven before outputs were off");
	a_oe_hold : assert property ($rose(oe_reg) |-> rd_valid_reg)
		else $error("output enable dropped before data was taken");
	a_read_wait : assert property (
		$fell(oe_reg) |-> !oe_reg [*5] ##1 rd_valid_reg)
		else $error("read data taken before access delay");
	a_strobe_pair : assert property (
		($fell(upper_byte_col_strobe_n_reg) && !lower_byte_col_strobe_n_reg) || ($fell(lower_byte_col_strobe_n_reg) && !upper_byte_col_strobe_n_reg)
		|-> $fell(upper_byte_col_strobe_n_reg) && $fell(lower_byte_col_strobe_n_reg))
		else $error("byte strobes staggered");
	a_strobe_rise : assert property (
		$rose(upper_byte_col_strobe_n_reg) || $rose(lower_byte_col_strobe_n_reg) |-> upper_byte_col_strobe_n_reg && lower_byte_col_strobe_n_reg)
		else $error("byte strobes rose apart");
	a_cbr_order : assert property (
		$fell(upper_byte_col_strobe_n_reg) && ras_reg && state_reg == ST_CBR_RAS |-> s_cas_lead ##1 !ras_reg)
		else $error("row strobe fell before column strobes in refresh");
	a_sr_window : assert property (
		$rose(ras_reg) |-> $past(ras_low_cnt) < 16'(SR_TRANS_CYC)
		|| $past(ras_low_cnt) >= 16'(SR_MIN_CYC - 1))
		else $error("row strobe released inside self refresh transition");
	a_sr_precharge : assert property (
		$rose(ras_reg) && sr_exit_q |-> ras_reg [*8] ##1 ras_reg [*6])
		else $error("self refresh precharge too short");
	a_sr_rows : assert property ($rose(sr_active_reg) |-> rows_ok)
		else $error("self refresh entered without full refresh");

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sr_exit_q <= 1'b0;
		end else begin
			sr_exit_q <= sr_exit;
		end
	end

endmodule // adcsr_ctrl

// file: verilog/adcsr_delay.sv
/*
 * Down counter that times every phase of the controller.
 * Assumes the caller loads (cycles - 1) at the edge that starts a phase.
 */
`timescale 1ns/1ps
module adcsr_delay
	import adcsr_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// load and status
	input wire logic load,
	input wire logic [adcsr_pkg::CNT_W-1:0] load_val,
	output logic done
);

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;

	assign cnt_next = load ? load_val : ((cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg);
	assign done = (cnt_reg == '0);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	a_dly_count : assert property (@(posedge clk) disable iff (!rst_n)
		(!load && cnt_reg != '0) |=> cnt_reg == $past(cnt_reg) - 1'b1)
		else $error("phase counter did not step down");

endmodule // adcsr_delay

// file: verilog/adcsr_refresh.sv
/*
 * Distributed refresh scheduler and row bookkeeping around self refresh.
 * Assumes cbr_done pulses once per finished column-before-row refresh and
 * sr_exit pulses once when the row strobe rises out of self refresh.
 */
`timescale 1ns/1ps
module adcsr_refresh
	import adcsr_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// events from the sequencer
	input wire logic cbr_done,
	input wire logic sr_exit,
	// status
	output logic ref_due,
	output logic rows_ok
);

	logic [CNT_W-1:0] int_reg;
	logic [CNT_W-1:0] int_next;
	logic [ROWS_W-1:0] rows_reg;
	logic [ROWS_W-1:0] rows_next;
	logic due_reg;
	logic due_next;
	logic due_set;

	// asking early leaves room for an access already under way
	assign due_set = sr_exit || (int_reg == CNT_W'(REF_INT_CYC - REF_SLACK_CYC));
	assign due_next = due_set ? 1'b1 : (cbr_done ? 1'b0 : due_reg);
	assign int_next = cbr_done ? '0 : int_reg + 1'b1;
	// rows restart at exit; a full sweep must pass before the next entry
	assign rows_next = sr_exit ? '0 :
		((cbr_done && rows_reg != ROWS_W'(ROWS_TOTAL)) ? rows_reg + 1'b1 : rows_reg);
	assign ref_due = due_reg;
	assign rows_ok = (rows_reg == ROWS_W'(ROWS_TOTAL));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			int_reg <= '0;
			rows_reg <= '0;
			due_reg <= 1'b0;
		end else begin
			int_reg <= int_next;
			rows_reg <= rows_next;
			due_reg <= due_next;
		end
	end

	a_ref_spacing : assert property (@(posedge clk) disable iff (!rst_n)
		int_reg <= CNT_W'(REF_INT_CYC))
		else $error("refresh spacing exceeded its interval");

	a_exit_due : assert property (@(posedge clk) disable iff (!rst_n)
		sr_exit |=> due_reg && rows_reg == '0)
		else $error("self refresh exit did not request a refresh");

endmodule // adcsr_refresh
